// *** iamss_brg.sv ***
// Baud period counter that reloads and counts down to zero.
`timescale 1ns/1ns
module iamss_brg #(
  parameter int W = 8
) (
  input wire logic clk_i, // Clock.
  input wire logic srst_i, // Synchronous reset.
  input wire logic load_i, // Reload the count.
  input wire logic run_i, // Count down while high.
  input wire logic [W-1:0] reload_i, // Reload value.
  output logic done_o // Count has reached zero.
);
  logic [W-1:0] cnt_reg, cnt_next;
  initial begin
    if (W < 1) $error("width too small");
  end
  always_comb begin
    cnt_next = cnt_reg;
    if (load_i) begin
      cnt_next = reload_i;
    end else if (run_i && cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
  // Done ignores load_i on purpose: the sequencer reloads in the done cycle itself.
  assign done_o = run_i && cnt_reg == '0;
endmodule

// *** iamss_pkg.sv ***
// Package with constants and types of the acknowledge and stop sequencer.
package iamss_pkg;
  localparam int BRG_W = 8;
  localparam logic [BRG_W-1:0] BRG_RELOAD_RST = 8'h09;
  localparam logic [7:0] BUF_RST = 8'h00;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ACK_LOW, ST_ACK_REL, ST_ACK_HIGH,
    ST_STP_SDA, ST_STP_WAIT, ST_STP_SCL, ST_STP_REL, ST_STP_DET, ST_STP_END
  } iamss_state_e;

  typedef struct packed {
    logic scl_oe;
    logic sda_oe;
  } iamss_line_s;
endpackage

// *** iamss_slave.sv ***
// Partner model of the two-wire bus with its pull-ups and a stretching slave.
`timescale 1ns/1ns
module iamss_slave (
  input wire logic clk_i, // Clock.
  input wire logic scl_oe_i, // Master pulls SCL.
  input wire logic sda_oe_i, // Master pulls SDA.
  input wire logic [3:0] stretch_i, // Stretch cycles.
  output logic scl_o, // SCL level.
  output logic sda_o // SDA level.
);
  logic [3:0] cnt = 4'h0;
  // The slave keeps SCL low for a while after the master lets go of it.
  always_ff @(posedge clk_i) begin
    cnt <= scl_oe_i ? stretch_i : cnt - 4'(cnt != 4'h0);
  end
  assign scl_o = !(scl_oe_i || cnt != 4'h0);
  assign sda_o = !sda_oe_i;
endmodule

// *** iamss_top.sv ***
// Acknowledge and stop condition sequencer of the serial port master.
// How it works
// - Setting the acknowledge enable pulls SCL low and puts the acknowledge data on SDA.
// - After one baud period with the bit driven, SCL is released.
// - Once SCL reads high, one more baud period passes and SCL is pulled low again.
// - On completion the acknowledge enable clears itself, the counter stops, the port idles.
// - A buffer write during an acknowledge sets the collision flag and is dropped.
// - Between sequences SCL stays held low after the ninth clock, but is left released after a stop.
// - Setting the stop enable pulls SDA low.
// - Once SDA reads low the counter reloads and counts to zero, then SCL is released.
// - One baud period after SCL is released, SDA is released.
// - SDA read high while SCL is high sets the stop-detected flag.
// - One baud period after detection the stop enable clears and the interrupt flag sets.
// - A buffer write during a stop sets the collision flag and is dropped.
`timescale 1ns/1ns
module iamss_top
  import iamss_pkg::*;
#(
  parameter int BRG_WIDTH = iamss_pkg::BRG_W
) (
  input wire logic CORE_CLK_I, // System clock.
  input wire logic SRST_I, // Synchronous reset, active high.
  input wire logic ACK_START_I, // Pulse: set the acknowledge enable.
  input wire logic STOP_START_I, // Pulse: set the stop enable.
  input wire logic ACK_DATA_VALUE_I, // Acknowledge data value.
  input wire logic [BRG_WIDTH-1:0] BAUD_RELOAD_I, // Baud period reload count.
  input wire logic BUF_WR_I, // Pulse: write to the transfer buffer.
  input wire logic [7:0] BUF_WDATA_I, // Write data.
  input wire logic WRITE_COLLISION_FLAG_CLR_I, // Pulse: clear the collision flag.
  input wire logic STOP_DET_CLR_I, // Pulse: clear the stop-detected flag.
  input wire logic IRQ_CLR_I, // Pulse: clear the port interrupt flag.
  input wire logic SCL_I, // SCL line level.
  input wire logic SDA_I, // SDA line level.
  output logic SCL_O, // SCL output value, always low.
  output logic SCL_OE_O, // SCL driven low when high.
  output logic SDA_O, // SDA output value, always low.
  output logic SDA_OE_O, // SDA driven low when high.
  output logic ACK_SEQUENCE_ENABLE_O, // Acknowledge sequence running.
  output logic STOP_SEQUENCE_ENABLE_O, // Stop sequence running.
  output logic WRITE_COLLISION_FLAG_O, // Sticky write collision flag.
  output logic STOP_DETECTED_O, // Sticky stop-detected flag.
  output logic PORT_INTERRUPT_FLAG_O, // Sticky port interrupt flag.
  output logic [7:0] TRANSFER_BUFFER_O // Transfer buffer contents.
);
  import iamss_pkg::*;

  initial begin
    if (BRG_WIDTH < 2 || BRG_WIDTH > 16) $error("BRG_WIDTH out of range");
  end

  // Both lines read high: the bus has been let go by everyone.
  function automatic logic bus_free(input logic scl, input logic sda);
    return scl && sda;
  endfunction

  // Two-stage synchronisers for the open-drain line inputs.
  // Every line change is seen two cycles late; that delay therefore
  // lengthens the high half, it never shortens it.
  logic scl_s1_reg, scl_s2_reg, sda_s1_reg, sda_s2_reg;
  logic scl_s1_next, scl_s2_next, sda_s1_next, sda_s2_next;
  always_comb begin
    scl_s1_next = SCL_I;
    scl_s2_next = scl_s1_reg;
    sda_s1_next = SDA_I;
    sda_s2_next = sda_s1_reg;
  end
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      // Reset to the pull-up level, so a released bus gives no false edge.
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
    end else begin
      scl_s1_reg <= scl_s1_next;
      scl_s2_reg <= scl_s2_next;
      sda_s1_reg <= sda_s1_next;
      sda_s2_reg <= sda_s2_next;
    end
  end

  // Sequencer state, line drivers and the software-visible flags.
  iamss_state_e state_reg, state_next;
  iamss_line_s line_reg, line_next;
  logic ack_en_reg, ack_en_next;
  logic stp_en_reg, stp_en_next;
  logic write_collision_flag_reg, write_collision_flag_next;
  logic pdet_reg, pdet_next;
  logic irq_reg, irq_next;
  logic [7:0] buf_reg, buf_next;
  logic brg_load, brg_run, brg_done;

  // One counter times every half period, so all edges share one reload count.
  iamss_brg #(
    .W(BRG_WIDTH)
  ) u_brg (
    .clk_i(CORE_CLK_I),
    .srst_i(SRST_I),
    .load_i(brg_load),
    .run_i(brg_run),
    .reload_i(BAUD_RELOAD_I),
    .done_o(brg_done)
  );

  // Sequencer: one state per line event, the counter timing each half period.
  always_comb begin
    state_next = state_reg;
    line_next = line_reg;
    ack_en_next = ack_en_reg;
    stp_en_next = stp_en_reg;
    brg_load = 1'b0;
    brg_run = 1'b0;
    unique case (state_reg)
      ST_IDLE: begin
        // Holding SCL low keeps the bus parked after the ninth clock.
        line_next.scl_oe = 1'b1;
        if (ACK_START_I) begin
          ack_en_next = 1'b1;
          line_next.sda_oe = !ACK_DATA_VALUE_I;
          brg_load = 1'b1;
          state_next = ST_ACK_LOW;
        end else if (STOP_START_I) begin
          stp_en_next = 1'b1;
          line_next.sda_oe = 1'b1;
          state_next = ST_STP_SDA;
        end
      end

      ST_ACK_LOW: begin
        // The counter was loaded with the start, so the bit stands a full period.
        brg_run = 1'b1;
        if (brg_done) begin
          line_next.scl_oe = 1'b0;
          state_next = ST_ACK_REL;
        end
      end

      ST_ACK_REL: begin
        // Counting waits for the line, so a stretching slave holds us off.
        if (scl_s2_reg) begin
          brg_load = 1'b1;
          state_next = ST_ACK_HIGH;
        end
      end

      ST_ACK_HIGH: begin
        brg_run = 1'b1;
        if (brg_done) begin
          line_next.scl_oe = 1'b1;
          line_next.sda_oe = 1'b0;
          ack_en_next = 1'b0;
          state_next = ST_IDLE;
        end
      end

      ST_STP_SDA: begin
        // Nothing is counted until SDA really reads low at the pin.
        if (!sda_s2_reg) begin
          brg_load = 1'b1;
          state_next = ST_STP_WAIT;
        end
      end

      ST_STP_WAIT: begin
        // Reloading in the done cycle keeps the two periods back to back.
        brg_run = 1'b1;
        if (brg_done) begin
          line_next.scl_oe = 1'b0;
          brg_load = 1'b1;
          state_next = ST_STP_SCL;
        end
      end

      ST_STP_SCL: begin
        brg_run = 1'b1;
        if (brg_done) begin
          line_next.sda_oe = 1'b0;
          state_next = ST_STP_REL;
        end
      end

      ST_STP_REL: begin
        if (bus_free(scl_s2_reg, sda_s2_reg)) begin
          brg_load = 1'b1;
          state_next = ST_STP_DET;
        end
      end

      ST_STP_DET: begin
        brg_run = 1'b1;
        if (brg_done) begin
          stp_en_next = 1'b0;
          state_next = ST_STP_END;
        end
      end

      ST_STP_END: begin
        // The bus stays released after a stop until software starts again.
        line_next.scl_oe = 1'b0;
        if (ACK_START_I) begin
          // A new acknowledge pulls SCL down first, just as from idle.
          ack_en_next = 1'b1;
          line_next.scl_oe = 1'b1;
          line_next.sda_oe = !ACK_DATA_VALUE_I;
          brg_load = 1'b1;
          state_next = ST_ACK_LOW;
        end else if (STOP_START_I) begin
          stp_en_next = 1'b1;
          line_next.sda_oe = 1'b1;
          state_next = ST_STP_SDA;
        end
      end

      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Sticky flags: a hardware set wins over a clear in the same cycle.
  always_comb begin
    write_collision_flag_next = write_collision_flag_reg;
    pdet_next = pdet_reg;
    irq_next = irq_reg;
    buf_next = buf_reg;
    if (WRITE_COLLISION_FLAG_CLR_I) begin
      write_collision_flag_next = 1'b0;
    end
    if (STOP_DET_CLR_I) begin
      pdet_next = 1'b0;
    end
    if (IRQ_CLR_I) begin
      irq_next = 1'b0;
    end
    // A write while a sequence runs is refused, so the shifter never sees a torn byte.
    if (BUF_WR_I) begin
      if (ack_en_reg || stp_en_reg) begin
        write_collision_flag_next = 1'b1;
      end else begin
        buf_next = BUF_WDATA_I;
      end
    end
    if (state_reg == ST_STP_REL && bus_free(scl_s2_reg, sda_s2_reg)) begin
      pdet_next = 1'b1;
    end
    if (state_reg == ST_STP_DET && brg_done) begin
      irq_next = 1'b1;
    end
  end

  // Sequencer registers.
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      state_reg <= ST_IDLE;
      line_reg <= '{scl_oe: 1'b0, sda_oe: 1'b0};
      ack_en_reg <= 1'b0;
      stp_en_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      line_reg <= line_next;
      ack_en_reg <= ack_en_next;
      stp_en_reg <= stp_en_next;
    end
  end

  // Flag and buffer registers.
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      write_collision_flag_reg <= 1'b0;
      pdet_reg <= 1'b0;
      irq_reg <= 1'b0;
      buf_reg <= BUF_RST;
    end else begin
      write_collision_flag_reg <= write_collision_flag_next;
      pdet_reg <= pdet_next;
      irq_reg <= irq_next;
      buf_reg <= buf_next;
    end
  end

  // Open-drain pins only ever pull low, so the data outputs stay zero.
  logic zero_reg, zero_next;
  always_comb begin
    zero_next = 1'b0;
  end
  always_ff @(posedge CORE_CLK_I) begin
    zero_reg <= zero_next;
  end

  assign SCL_O = zero_reg;
  assign SDA_O = zero_reg;
  assign SCL_OE_O = line_reg.scl_oe;
  assign SDA_OE_O = line_reg.sda_oe;
  assign ACK_SEQUENCE_ENABLE_O = ack_en_reg;
  assign STOP_SEQUENCE_ENABLE_O = stp_en_reg;
  assign WRITE_COLLISION_FLAG_O = write_collision_flag_reg;
  assign STOP_DETECTED_O = pdet_reg;
  assign PORT_INTERRUPT_FLAG_O = irq_reg;
  assign TRANSFER_BUFFER_O = buf_reg;
endmodule

// *** iamss_top_sva.sv ***
// Port checker of the acknowledge and stop sequencer.
`timescale 1ns/1ns
module iamss_chk #(
  parameter int BRG_WIDTH = 8
) (
  input wire logic CORE_CLK_I, // Clock.
  input wire logic SRST_I, // Reset.
  input wire logic ACK_START_I, // Ack go.
  input wire logic STOP_START_I, // Stop go.
  input wire logic ACK_DATA_VALUE_I, // Ack bit.
  input wire logic [BRG_WIDTH-1:0] BAUD_RELOAD_I, // Reload.
  input wire logic BUF_WR_I, // Write.
  input wire logic SCL_OE_O, // SCL pull.
  input wire logic SDA_OE_O, // SDA pull.
  input wire logic ACK_SEQUENCE_ENABLE_O, // Ack run.
  input wire logic STOP_SEQUENCE_ENABLE_O, // Stop run.
  input wire logic WRITE_COLLISION_FLAG_O, // Collision.
  input wire logic STOP_DETECTED_O, // Stop seen.
  input wire logic PORT_INTERRUPT_FLAG_O, // Interrupt.
  input wire logic [7:0] TRANSFER_BUFFER_O // Buffer.
);
  logic idle;
  logic [BRG_WIDTH:0] hi_cnt_reg;
  logic [BRG_WIDTH:0] hi_cnt_next;
  assign idle = !ACK_SEQUENCE_ENABLE_O && !STOP_SEQUENCE_ENABLE_O;
  // Length of the first half of the acknowledge bit, while SCL is pulled.
  always_comb begin
    hi_cnt_next = (!SRST_I && ACK_SEQUENCE_ENABLE_O && SCL_OE_O) ? hi_cnt_reg + 1'b1 : '0;
  end
  always_ff @(posedge CORE_CLK_I) begin
    hi_cnt_reg <= hi_cnt_next;
  end
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (SRST_I);
  ack_start_a: assert property (
    ACK_START_I && idle |=> ACK_SEQUENCE_ENABLE_O && SCL_OE_O
      && SDA_OE_O == !$past(ACK_DATA_VALUE_I)) else $error("ack start");
  stop_start_a: assert property (
    STOP_START_I && !ACK_START_I && idle |=> STOP_SEQUENCE_ENABLE_O && SDA_OE_O)
    else $error("stop start");
  coll_set_a: assert property (
    BUF_WR_I && !idle |=> WRITE_COLLISION_FLAG_O && $stable(TRANSFER_BUFFER_O))
    else $error("collision");
  ack_period_a: assert property (
    ACK_SEQUENCE_ENABLE_O && $fell(SCL_OE_O) |-> hi_cnt_reg == {1'b0, BAUD_RELOAD_I} + 1'b1)
    else $error("ack period");
  ack_end_a: assert property (
    $fell(ACK_SEQUENCE_ENABLE_O) |-> SCL_OE_O && !SDA_OE_O) else $error("ack end");
  stop_order_a: assert property (
    STOP_SEQUENCE_ENABLE_O && $fell(SCL_OE_O) |-> SDA_OE_O) else $error("stop order");
  stop_det_a: assert property (
    $rose(STOP_DETECTED_O) |-> STOP_SEQUENCE_ENABLE_O && !SCL_OE_O && !SDA_OE_O)
    else $error("stop detect");
  stop_end_a: assert property (
    $fell(STOP_SEQUENCE_ENABLE_O) |-> PORT_INTERRUPT_FLAG_O && STOP_DETECTED_O)
    else $error("stop end");
endmodule
bind iamss_top iamss_chk #(.BRG_WIDTH(BRG_WIDTH)) iamss_chk_i (.*);

// *** test_iamss_top.sv ***
// Self-checking bench of the acknowledge and stop sequencer.
`timescale 1ns/1ns
module test_iamss_top;
  import iamss_pkg::*;
  localparam int N = 3;
  localparam int P = N + 1;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ack_go = 1'b0, stop_go = 1'b0, ack_dv = 1'b0, wr = 1'b0;
  logic write_collision_flag_clr = 1'b0, det_clr = 1'b0, irq_clr = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [3:0] stretch = 4'h0;
  logic [BRG_W-1:0] reload = BRG_W'(N);
  logic scl, sda, ack_en, stop_en, write_collision_flag, det, irq;
  logic [7:0] buf_q;
  wire iamss_line_s oe;
  int n_mismatch = 0;
  int checks = 0;
  int n;
  iamss_top #(.BRG_WIDTH(BRG_W)) iamss_top_i (.CORE_CLK_I(clk), .SRST_I(rst),
    .ACK_START_I(ack_go), .STOP_START_I(stop_go), .ACK_DATA_VALUE_I(ack_dv),
    .BAUD_RELOAD_I(reload), .BUF_WR_I(wr), .BUF_WDATA_I(wdata), .WRITE_COLLISION_FLAG_CLR_I(write_collision_flag_clr),
    .STOP_DET_CLR_I(det_clr), .IRQ_CLR_I(irq_clr), .SCL_I(scl), .SDA_I(sda), .SCL_O(),
    .SCL_OE_O(oe.scl_oe), .SDA_O(), .SDA_OE_O(oe.sda_oe), .ACK_SEQUENCE_ENABLE_O(ack_en),
    .STOP_SEQUENCE_ENABLE_O(stop_en), .WRITE_COLLISION_FLAG_O(write_collision_flag), .STOP_DETECTED_O(det),
    .PORT_INTERRUPT_FLAG_O(irq), .TRANSFER_BUFFER_O(buf_q));
  iamss_slave iamss_slave_i (.clk_i(clk), .scl_oe_i(oe.scl_oe), .sda_oe_i(oe.sda_oe),
    .stretch_i(stretch), .scl_o(scl), .sda_o(sda));
  always #50 clk = ~clk;
  task step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask
  task chk(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t bit %b not %b", $time, got, exp);
    end
  endtask
  task chk8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t byte %h not %h", $time, got, exp);
    end
  endtask
  function automatic logic pick(input int s);
    return s == 0 ? ack_en : s == 1 ? oe.scl_oe : s == 2 ? det : stop_en;
  endfunction
  // Bounded wait; n returns the cycles spent.
  task wait_for(input int s, input logic v);
    n = 0;
    while (pick(s) !== v && n < 300) begin
      step(1);
      n++;
    end
    chk(pick(s), v);
  endtask
  task t_buf;
    chk8(buf_q, BUF_RST);
    wdata = 8'h3c;
    pulse(wr);
    chk8(buf_q, 8'h3c);
    $display("test buffer done");
  endtask
  task t_ack(input logic d, input logic [3:0] s);
    ack_dv = d;
    stretch = s;
    pulse(ack_go);
    wait_for(0, 1'b1);
    chk(oe.sda_oe, !d);
    wdata = 8'ha5;
    pulse(wr);
    chk(write_collision_flag, 1'b1);
    chk8(buf_q, 8'h3c);
    wait_for(1, 1'b0);
    chk(n == P - 1, 1'b1);
    wait_for(0, 1'b0);
    chk(n > s + P, 1'b1);
    chk(oe.sda_oe, 1'b0);
    step(3);
    chk(oe.scl_oe, 1'b1);
    pulse(write_collision_flag_clr);
    chk(write_collision_flag, 1'b0);
    $display("test ack done");
  endtask
  task t_stop;
    int per;
    reload = 8'h05;
    per = int'(reload) + 1;
    stretch = 4'h0;
    pulse(stop_go);
    wait_for(3, 1'b1);
    chk(oe.sda_oe, 1'b1);
    wdata = 8'h96;
    pulse(wr);
    chk(write_collision_flag, 1'b1);
    chk8(buf_q, 8'h3c);
    wait_for(1, 1'b0);
    chk(oe.sda_oe, 1'b1);
    step(per - 1);
    chk(oe.sda_oe, 1'b1);
    step(1);
    chk(oe.sda_oe, 1'b0);
    wait_for(2, 1'b1);
    chk(stop_en, 1'b1);
    wait_for(3, 1'b0);
    chk(n == per, 1'b1);
    chk(irq, 1'b1);
    pulse(det_clr);
    pulse(irq_clr);
    chk(det | irq, 1'b0);
    reload = BRG_W'(N);
    $display("test stop done");
  endtask
  initial begin
    step(12);
    rst = 1'b0;
    step(1);
    t_buf;
    t_ack(1'b0, 4'h0);
    t_ack(1'b1, 4'h5);
    t_stop;
    t_ack(1'b0, 4'h2);
    results;
  end
  initial begin
    #500000;
    n_mismatch++;
    results;
  end
  task results;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
endmodule
